// ---- mbt_ctrl_words.sv ----
// buffer control and tone/dial control words with their datapath effects
`timescale 1ns/1ps
module mbt_ctrl_words (
  input  wire logic        ref_clk,      // 20 MHz clock
  input  wire logic        rst,          // async reset, high
  input  wire logic        ramWrite,     // host indirect write strobe
  input  wire logic        ramRead,      // host indirect read strobe
  input  wire logic [8:0]  ramAddr,      // indirect word address
  input  wire logic [15:0] ramWrData,    // indirect write data
  output logic      [15:0] ramRdData,    // read data, registered
  output logic             ramHit,       // address maps here
  input  wire logic        modeWrite,    // host writes config mode
  input  wire logic [3:0]  modeValue,    // config mode value
  input  wire logic        parallelSel,  // parallel transfer selected
  input  wire logic        pskMode,      // 1200/2400 psk/qam mode
  input  wire logic        rawHitA,      // detector A (or cascade) hit
  input  wire logic        rawHitB,      // detector B hit
  input  wire logic        txHostBit,    // tx data from host
  input  wire logic        txScrBit,     // tx data after scrambler
  input  wire logic        rxLineBit,    // rx data, descrambled
  input  wire logic        rxRawBit,     // rx data, not descrambled
  output logic             txBit,        // bit to modulator
  output logic             rxBit,        // bit to host
  output logic             txScrActive,  // scrambler in use
  output logic             rxDscrActive, // descrambler in use
  output logic             hdlcFraming,  // hdlc framing engaged
  output logic             cascadeOn,    // biquads cascaded
  output logic             squarerOff,   // squarer bypassed
  output logic             dtmfDial,     // dial with DTMF
  output logic             pulseDial,    // dial with pulses
  output logic             timedDial,    // timed dialing
  output logic      [3:0]  dialDigit,    // digit to dial
  output logic             digitValid    // digit legal for method
);
  // ********************************************************
  // storage and decode
  // ********************************************************
  logic [15:0] bufWord;   // buffer control word
  logic [15:0] toneWord;  // tone detect and dial word
  logic        curMode3;  // config mode is dialing
  logic        txMid;     // tx after scramble select
  logic        rxMid;     // rx after descramble select
  wire selBuf;            // write to buffer word
  wire selTone;           // write to tone word
  wire clrHits;           // mode 2 written
  wire setA;              // detector A event
  wire setB;              // detector B event
  wire [15:0] next_tone;  // tone word next value
  mbt_pkg::mbt_dial_t dialMethod; // dial method decode

  assign selBuf  = ramWrite & (ramAddr == mbt_pkg::ADDR_BUF_WORD);
  assign selTone = ramWrite & (ramAddr == mbt_pkg::ADDR_TONE_WORD);
  assign ramHit  = (ramAddr == mbt_pkg::ADDR_BUF_WORD) |
                   (ramAddr == mbt_pkg::ADDR_TONE_WORD);
  assign clrHits = modeWrite & (modeValue == mbt_pkg::MODE_CLEAR_HITS);
  // detectors run on this clock, so their hits need no synchroniser
  assign setA    = rawHitA;
  assign setB    = rawHitB;
  // host owns the low bits; hit flags are set by hardware, set beats clear
  assign next_tone = {
    setA | (toneWord[mbt_pkg::TONE_HIT_A] & ~clrHits),
    setB | (toneWord[mbt_pkg::TONE_HIT_B] & ~clrHits),
    (selTone ? ramWrData[13:0] : toneWord[13:0])};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)         bufWord <= mbt_pkg::RST_BUF_WORD;
    else if (selBuf) bufWord <= ramWrData;
  end

  // tone word reset, write and event update
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) toneWord <= mbt_pkg::RST_TONE_WORD;
    else     toneWord <= next_tone;
  end

  // remember the mode so dialing follows the last config write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)            curMode3 <= 1'b0;
    else if (modeWrite) curMode3 <= (modeValue == mbt_pkg::MODE_DIALING);
  end

  // zero for a stray address keeps a stale word from looking valid
  // registered read path, unmapped reads return zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) ramRdData <= 16'h0000;
    else if (ramRead) begin
      ramRdData <= (ramAddr == mbt_pkg::ADDR_BUF_WORD)  ? bufWord  :
                   (ramAddr == mbt_pkg::ADDR_TONE_WORD) ? toneWord :
                   16'h0000;
    end
  end

  // ********************************************************
  // buffer word effects
  // ********************************************************
  // framing only in parallel mode
  assign hdlcFraming = parallelSel & bufWord[mbt_pkg::BUF_FRAMING_BIT];

  // tx scrambler bypass, overrides sequence select
  mbt_scram_gate txScr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .psk     (pskMode),
    .bypass  (bufWord[mbt_pkg::BUF_TX_SCR_OFF]),
    .plain   (txHostBit),
    .coded   (txScrBit),
    .bitOut  (txMid),
    .active  (txScrActive)
  );
  mbt_scram_gate rxScr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .psk     (pskMode),
    .bypass  (bufWord[mbt_pkg::BUF_RX_DSCR_OFF]),
    .plain   (rxRawBit),
    .coded   (rxLineBit),
    .bitOut  (rxMid),
    .active  (rxDscrActive)
  );
  mbt_mark_gate txMark (
    .ref_clk (ref_clk),
    .rst     (rst),
    .hold    (bufWord[mbt_pkg::BUF_TX_MARK_HOLD]),
    .bitIn   (txMid),
    .bitOut  (txBit)
  );
  mbt_mark_gate rxMark (
    .ref_clk (ref_clk),
    .rst     (rst),
    .hold    (bufWord[mbt_pkg::BUF_RX_MARK_HOLD]),
    .bitIn   (rxMid),
    .bitOut  (rxBit)
  );

  // ********************************************************
  // tone word effects
  // ********************************************************
  // cascade; combined hit arrives on rawHitA
  assign cascadeOn  = toneWord[mbt_pkg::TONE_CASCADE];
  assign squarerOff = cascadeOn & toneWord[mbt_pkg::TONE_SQR_BYPASS];
  assign timedDial  = toneWord[mbt_pkg::TONE_TIMED];
  // digit field, 0-9 keys then star, hash, A-D
  assign dialDigit  = toneWord[mbt_pkg::TONE_DIGIT_MSB:0];
  // the digit is passed on as stored; legality is judged below

  always_comb begin
    dialMethod = mbt_pkg::DIAL_IDLE;
    if (curMode3) begin
      if (toneWord[mbt_pkg::TONE_DIAL_SEL]) dialMethod = mbt_pkg::DIAL_DTMF;
      else dialMethod = mbt_pkg::DIAL_PULSE;
    end
  end

  // one-hot method decode to outputs
  always_comb begin
    dtmfDial  = 1'b0;
    pulseDial = 1'b0;
    case (dialMethod)
      mbt_pkg::DIAL_IDLE:  dtmfDial = 1'b0;
      mbt_pkg::DIAL_DTMF:  dtmfDial = 1'b1;
      mbt_pkg::DIAL_PULSE: pulseDial = 1'b1;
      default:             dtmfDial = 1'b0;
    endcase
  end

  // pulse digits above nine flagged by digitValid; pulseDial stays set
  assign digitValid = ~pulseDial | (dialDigit <= mbt_pkg::DIGIT_MAX_PULSE);

  // ********************************************************
  // assertions
  // ********************************************************
  // every property samples on the block clock and sleeps during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // short names for watched fields keep the properties readable
  wire flagA    = toneWord[mbt_pkg::TONE_HIT_A];       // detector A flag
  wire flagB    = toneWord[mbt_pkg::TONE_HIT_B];       // detector B flag
  wire dialSel  = toneWord[mbt_pkg::TONE_DIAL_SEL];    // dtmf requested
  wire framing  = bufWord[mbt_pkg::BUF_FRAMING_BIT];   // framing bit
  wire txHold   = bufWord[mbt_pkg::BUF_TX_MARK_HOLD];  // tx mark hold
  wire rxHold   = bufWord[mbt_pkg::BUF_RX_MARK_HOLD];  // rx mark hold
  wire txScrOff = bufWord[mbt_pkg::BUF_TX_SCR_OFF];    // tx bypass bit
  wire rxScrOff = bufWord[mbt_pkg::BUF_RX_DSCR_OFF];   // rx bypass bit

  hit_a_set_a: assert property (rawHitA |=> flagA)
    else $error("detector A hit not recorded");
  hit_a_clr_a: assert property ((clrHits && !rawHitA) |=> !flagA)
    else $error("detector A flag not cleared by mode 2");
  hit_a_hold_a: assert property (
    (!clrHits && !rawHitA && flagA) |=> flagA)
    else $error("detector A flag lost");
  hit_a_quiet_a: assert property (
    (!rawHitA && !flagA) |=> !flagA)
    else $error("detector A flag set without a hit");
  hit_b_set_a: assert property (rawHitB |=> flagB)
    else $error("detector B hit not recorded");
  hit_b_clr_a: assert property ((clrHits && !rawHitB) |=> !flagB)
    else $error("detector B flag not cleared by mode 2");
  hit_b_hold_a: assert property (
    (!clrHits && !rawHitB && flagB) |=> flagB)
    else $error("detector B flag lost");
  buf_write_a: assert property (
    selBuf |=> bufWord == $past(ramWrData))
    else $error("buffer word write lost");
  buf_hold_a: assert property (!selBuf |=> $stable(bufWord))
    else $error("buffer word changed without a write");
  tone_write_a: assert property (
    selTone |=> toneWord[13:0] == $past(ramWrData[13:0]))
    else $error("tone word write lost");
  tone_read_a: assert property (
    (ramRead && ramAddr == mbt_pkg::ADDR_TONE_WORD) |=> ramRdData == $past(toneWord))
    else $error("tone read wrong");
  buf_read_a: assert property (
    (ramRead && ramAddr == mbt_pkg::ADDR_BUF_WORD) |=> ramRdData == $past(bufWord))
    else $error("buffer read wrong");
  tx_mark_a: assert property (txHold && $past(txHold) |=> txBit)
    else $error("tx not held at mark");
  rx_mark_a: assert property (rxHold && $past(rxHold) |=> rxBit)
    else $error("rx not held at mark");
  serial_frame_a: assert property (!parallelSel |-> !hdlcFraming)
    else $error("framing active in serial mode");
  frame_par_a: assert property (
    (parallelSel && framing) |-> hdlcFraming)
    else $error("framing missing in parallel mode");
  sqr_gate_a: assert property (!cascadeOn |-> !squarerOff)
    else $error("squarer bypass without cascade");
  tx_scr_a: assert property (
    (pskMode && txScrOff) |=> !txScrActive)
    else $error("tx scrambler not bypassed");
  tx_scr_on_a: assert property (!txScrOff |=> txScrActive)
    else $error("tx scrambler dropped without bypass");
  rx_dscr_a: assert property (
    (pskMode && rxScrOff) |=> !rxDscrActive)
    else $error("rx descrambler not bypassed");
  rx_dscr_on_a: assert property (!rxScrOff |=> rxDscrActive)
    else $error("rx descrambler dropped without bypass");
  scr_psk_only_a: assert property (
    !pskMode |=> (txScrActive && rxDscrActive))
    else $error("scrambler bypassed outside psk/qam");
  dtmf_sel_a: assert property (
    (curMode3 && dialSel) |-> (dtmfDial && !pulseDial))
    else $error("dtmf dialing not selected");
  pulse_sel_a: assert property (
    (curMode3 && !dialSel) |-> (pulseDial && !dtmfDial))
    else $error("pulse dialing not selected");
  dial_idle_a: assert property (
    !curMode3 |-> (!dtmfDial && !pulseDial))
    else $error("dialing outside dialing mode");
  pulse_digit_a: assert property (
    (pulseDial && dialDigit > mbt_pkg::DIGIT_MAX_PULSE) |-> !digitValid)
    else $error("illegal pulse digit accepted");
  mode_latch_a: assert property (
    modeWrite |=> curMode3 == ($past(modeValue) == mbt_pkg::MODE_DIALING))
    else $error("dialing mode not latched");

  cov_hdlc_c:    cover property (selBuf ##1 hdlcFraming);
  cov_clear_c:   cover property (flagA ##1 clrHits ##1 !flagA);
  cov_dtmf_c:    cover property (dtmfDial && timedDial);
  cov_pulse_c:   cover property (pulseDial && !digitValid);
  cov_cascade_c: cover property (cascadeOn && rawHitA ##1 flagA);
endmodule : mbt_ctrl_words

// ---- mbt_host_model.sv ----
// host model: indirect ram word access and config mode writes
`timescale 1ns/1ps
module mbt_host_model (
  input  wire logic        ref_clk,   // clock
  input  wire logic [15:0] ramRdData, // read data from block
  output logic             ramWrite,  // write strobe
  output logic             ramRead,   // read strobe
  output logic      [8:0]  ramAddr,   // word address
  output logic      [15:0] ramWrData, // write data
  output logic             modeWrite, // config mode strobe
  output logic      [3:0]  modeValue  // config mode value
);
  // ********************************************************
  // bus tasks
  // ********************************************************
  initial begin
    ramWrite = 1'b0;
    ramRead = 1'b0;
    modeWrite = 1'b0;
    ramAddr = 9'h000;
    ramWrData = 16'h0000;
    modeValue = 4'h0;
  end
  // released data is inverted so a stale word can never pass as new
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge ref_clk) #1;
    ramAddr = a;
    ramWrData = d;
    ramWrite = 1'b1;
    @(posedge ref_clk) #1;
    ramWrite = 1'b0;
    ramWrData = ~d;
  endtask : wr
  // read data is taken one edge after the strobe
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge ref_clk) #1;
    ramAddr = a;
    ramRead = 1'b1;
    @(posedge ref_clk) #1;
    ramRead = 1'b0;
    d = ramRdData;
  endtask : rd
  task automatic mode(input logic [3:0] m);
    @(posedge ref_clk) #1;
    modeValue = m;
    modeWrite = 1'b1;
    @(posedge ref_clk) #1;
    modeWrite = 1'b0;
    modeValue = ~m;
  endtask : mode
endmodule : mbt_host_model

// ---- mbt_mark_gate.sv ----
// forces a serial bit to mark while hold is set
`timescale 1ns/1ps
module mbt_mark_gate (
  input  wire logic ref_clk,  // clock
  input  wire logic rst,      // async reset, high
  input  wire logic hold,     // force marks
  input  wire logic bitIn,    // data bit in
  output logic      bitOut    // registered bit out
);
  // ********************************************************
  // gate register
  // ********************************************************
  // mark is binary one, so reset idles the line at mark
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) bitOut <= 1'b1;
    else     bitOut <= hold | bitIn;
  end
endmodule : mbt_mark_gate

// ---- mbt_pkg.sv ----
// package: word addresses, field positions, reset values and modes
package mbt_pkg;
  // ********************************************************
  // word addresses in internal ram and reset values
  // ********************************************************
  localparam logic [8:0]  ADDR_TONE_WORD  = 9'h1fc;
  localparam logic [8:0]  ADDR_BUF_WORD   = 9'h1fd;
  localparam logic [15:0] RST_TONE_WORD   = 16'h0080;
  localparam logic [15:0] RST_BUF_WORD    = 16'h0000;
  // ********************************************************
  // buffer control word field positions
  // ********************************************************
  localparam int BUF_FRAMING_BIT   = 7;
  localparam int BUF_TX_SCR_OFF    = 3;
  localparam int BUF_TX_MARK_HOLD  = 2;
  localparam int BUF_RX_DSCR_OFF   = 1;
  localparam int BUF_RX_MARK_HOLD  = 0;
  localparam logic [15:0] BUF_HIGH_MASK = 16'hff00;
  // ********************************************************
  // tone word field positions
  // ********************************************************
  localparam int TONE_HIT_A        = 15;
  localparam int TONE_HIT_B        = 14;
  localparam int TONE_CASCADE      = 13;
  localparam int TONE_DIAL_SEL     = 7;
  localparam int TONE_SQR_BYPASS   = 5;
  localparam int TONE_TIMED        = 4;
  localparam int TONE_DIGIT_MSB    = 3;
  localparam logic [15:0] TONE_HW_MASK = 16'hc000;
  // ********************************************************
  // configuration modes and digits
  // ********************************************************
  localparam logic [3:0] MODE_CLEAR_HITS = 4'h2;
  localparam logic [3:0] MODE_DIALING    = 4'h3;
  localparam logic [3:0] DIGIT_STAR      = 4'ha;
  localparam logic [3:0] DIGIT_HASH      = 4'hb;
  localparam logic [3:0] DIGIT_MAX_PULSE = 4'h9;
  // dial method decode, one-hot
  typedef enum logic [2:0] {
    DIAL_IDLE  = 3'b001,
    DIAL_DTMF  = 3'b010,
    DIAL_PULSE = 3'b100
  } mbt_dial_t;
endpackage : mbt_pkg

// ---- mbt_scram_gate.sv ----
// selects scrambled or plain data path per bypass control in psk/qam modes
`timescale 1ns/1ps
module mbt_scram_gate (
  input  wire logic ref_clk,  // clock
  input  wire logic rst,      // async reset, high
  input  wire logic psk,      // psk/qam mode active
  input  wire logic bypass,   // scrambler bypass request
  input  wire logic plain,    // unscrambled bit
  input  wire logic coded,    // scrambled bit
  output logic      bitOut,   // registered selected bit
  output logic      active    // scrambling in use
);
  wire useCoded;  // bypass only acts in psk/qam modes
  assign useCoded = ~(bypass & psk);
  // ********************************************************
  // select register
  // ********************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bitOut <= 1'b1;
      active <= 1'b0;
    end else begin
      bitOut <= useCoded ? coded : plain;
      active <= useCoded;
    end
  end
endmodule : mbt_scram_gate

// ---- tb.sv ----
// self-checking bench for the control word block
`timescale 1ns/1ps
module tb;
  logic ref_clk, rst, ramWrite, ramRead, ramHit, modeWrite;
  logic [8:0] ramAddr;
  logic [15:0] ramWrData, ramRdData;
  logic [3:0] modeValue, dialDigit;
  logic parallelSel, pskMode, rawHitA, rawHitB;
  logic txHostBit, txScrBit, rxLineBit, rxRawBit, txBit, rxBit;
  logic txScrActive, rxDscrActive, hdlcFraming, cascadeOn;
  logic squarerOff, dtmfDial, pulseDial, timedDial, digitValid;
  int nErrors, checksDone, cycles;
  localparam logic [8:0] AT = mbt_pkg::ADDR_TONE_WORD;
  localparam logic [8:0] AB = mbt_pkg::ADDR_BUF_WORD;
  // ********************************************************
  // clock, instances, timeout
  // ********************************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  mbt_ctrl_words dut_u (.ref_clk, .rst, .ramWrite, .ramRead, .ramAddr,
    .ramWrData, .ramRdData, .ramHit, .modeWrite, .modeValue,
    .parallelSel, .pskMode, .rawHitA, .rawHitB, .txHostBit, .txScrBit,
    .rxLineBit, .rxRawBit, .txBit, .rxBit, .txScrActive, .rxDscrActive,
    .hdlcFraming, .cascadeOn, .squarerOff, .dtmfDial, .pulseDial,
    .timedDial, .dialDigit, .digitValid);
  mbt_host_model host_u (.ref_clk, .ramRdData, .ramWrite, .ramRead,
    .ramAddr, .ramWrData, .modeWrite, .modeValue);
  // whole run needs under 1000 cycles; the ceiling leaves margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      nErrors++;
      testDone();
    end
  end
  // ********************************************************
  // compare and helper tasks
  // ********************************************************
  task automatic chk16(input string nm, input logic [15:0] g, e);
    checksDone++;
    if (g !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16
  task automatic chk1(input string nm, input logic g, e);
    checksDone++;
    if (g !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic rdchk(input logic [8:0] a, input logic [15:0] e);
    logic [15:0] d;
    host_u.rd(a, d);
    chk16("ramRdData", d, e);
  endtask : rdchk
  task automatic pulse(ref logic s);
    @(posedge ref_clk) #1;
    s = 1'b1;
    @(posedge ref_clk) #1;
    s = 1'b0;
  endtask : pulse
  // data path: host 0 / scrambled 1, rx descrambled 0 / raw 1
  task automatic dpath(input logic [15:0] w, input logic et, ea, er, eb);
    host_u.wr(AB, w);
    repeat (3) @(posedge ref_clk);
    #2;
    chk1("txBit", txBit, et);
    chk1("txScrActive", txScrActive, ea);
    chk1("rxBit", rxBit, er);
    chk1("rxDscrActive", rxDscrActive, eb);
  endtask : dpath
  task automatic testDone();
    if (nErrors == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : testDone
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic tRegs();
    rdchk(AT, 16'h0080);
    rdchk(AB, 16'h0000);
    rdchk(9'h1fe, 16'h0000);
    chk1("ramHit", ramHit, 1'b0);
    host_u.wr(AB, 16'hff0f);
    rdchk(AB, 16'hff0f);
    chk1("ramHit", ramHit, 1'b1);
    host_u.wr(AT, 16'hffff);
    rdchk(AT, 16'h3fff);
    chk1("ramHit", ramHit, 1'b1);
    host_u.wr(AT, 16'h0080);
    host_u.wr(AB, 16'h0000);
  endtask : tRegs
  task automatic tHits();
    pulse(rawHitA);
    rdchk(AT, 16'h8080);
    pulse(rawHitB);
    rdchk(AT, 16'hc080);
    // a hit landing in the clearing cycle must survive the clear
    fork
      pulse(rawHitB);
      host_u.mode(4'h2);
    join
    rdchk(AT, 16'h4080);
    host_u.mode(4'h2);
    rdchk(AT, 16'h0080);
    host_u.wr(AT, 16'h2020);
    chk1("cascadeOn", cascadeOn, 1'b1);
    chk1("squarerOff", squarerOff, 1'b1);
    pulse(rawHitA);
    rdchk(AT, 16'ha020);
    host_u.wr(AT, 16'h0020);
    chk1("squarerOff", squarerOff, 1'b0);
    host_u.mode(4'h2);
  endtask : tHits
  task automatic tDial();
    host_u.wr(AT, 16'h0095);
    host_u.mode(4'h3);
    chk1("dtmfDial", dtmfDial, 1'b1);
    chk1("timedDial", timedDial, 1'b1);
    for (int m = 0; m < 2; m++) begin
      for (int d = 0; d < 16; d++) begin
        host_u.wr(AT, {8'h00, m[0], 3'b000, d[3:0]});
        chk1("pulseDial", pulseDial, ~m[0]);
        chk1("timedDial", timedDial, 1'b0);
        chk16("dialDigit", {12'h000, dialDigit}, d[15:0]);
        chk1("digitValid", digitValid, m[0] | (d < 10));
      end
    end
    host_u.mode(4'h0);
    chk1("dtmfDial", dtmfDial, 1'b0);
  endtask : tDial
  task automatic tData();
    host_u.wr(AB, 16'h0080);
    parallelSel = 1'b1;
    #1;
    chk1("hdlcFraming", hdlcFraming, 1'b1);
    @(posedge ref_clk) #1;
    parallelSel = 1'b0;
    #1;
    chk1("hdlcFraming", hdlcFraming, 1'b0);
    @(posedge ref_clk) #1;
    pskMode = 1'b1;
    dpath(16'h0000, 1'b1, 1'b1, 1'b0, 1'b1);
    dpath(16'h0008, 1'b0, 1'b0, 1'b0, 1'b1);
    dpath(16'h000c, 1'b1, 1'b0, 1'b0, 1'b1);
    dpath(16'h0002, 1'b1, 1'b1, 1'b1, 1'b0);
    dpath(16'h0001, 1'b1, 1'b1, 1'b1, 1'b1);
    // outside psk/qam the bypass bits must leave both scramblers in
    @(posedge ref_clk) #1;
    pskMode = 1'b0;
    dpath(16'h000a, 1'b1, 1'b1, 1'b0, 1'b1);
  endtask : tData
  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    rst = 1'b1;
    {parallelSel, pskMode, rawHitA, rawHitB} = 4'h0;
    {txHostBit, txScrBit, rxLineBit, rxRawBit} = 4'b0101;
    nErrors = 0;
    checksDone = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    tRegs();
    tHits();
    tDial();
    tData();
    testDone();
  end
endmodule : tb
